// file: rtl/vbi_sliced_data_packetizer.sv
// How it works
// - line select low nibble picks service; 1110 and 1111 both disable capture
// - teletext results go only to the fifo, never to result registers
// - every access to the config ram port advances its address counter
// - lines 6 to 27 of both fields each carry their own service select
// - results readable through fifo port or result registers on host port
// - packet goes out in horizontal blanking of the line after slicing
// - fifo holds 512 bytes in the same layout as the stream packet
// - preamble 00 ff ff, then data id, secondary id, count, two line ids
// - data id 91/53 for field one, 55/97 for field two, split at line 24
// - id bytes carry even parity in bit 6 and its inverse in bit 7
// - data id bits 5:3 are 010; secondary id holds the service code
// - count byte holds dwords from byte 8 through packet end
// - line id bytes carry line number, match flags and error flag
// - checksum is low six bits of sum from data id through last data
// - fill bytes 80 pad the packet to a multiple of four bytes
// - raw mode sends converter samples in active and vertical blanking
// - insertion only in embedded sync mode, not with discrete syncs
`timescale 1ns/1ps
`include "vsdp_defs.svh"

module vbi_sliced_data_packetizer
	import vsdp_pkg::*;
(
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [7:0] REG_RDATA,
	input wire logic SLICE_START,
	input wire vsdp_slice_t SLICE_INFO,
	input wire logic SLICE_BYTE_VALID,
	input wire logic [7:0] SLICE_BYTE,
	input wire logic SLICE_END,
	input wire logic HBLANK,
	input wire logic ACTIVE,
	input wire logic VBLANK,
	input wire logic [7:0] VID_IN,
	input wire logic [7:0] RAW_SAMPLE,
	output logic [7:0] VID_OUT,
	output logic ANC_ACTIVE,
	output logic FIFO_NONEMPTY
);

	function automatic logic [7:0] add_id_parity(input logic [5:0] v);
		logic p;
		p = ^v;
		return {~p, p, v};
	endfunction : add_id_parity

	// ----------------------------------------
	// host registers
	// ----------------------------------------
	logic [7:0] ctrl_reg;
	logic [7:0] lmode_reg [`VSDP_NUM_LMODE];
	logic [7:0] result_reg [`VSDP_RESULT_REGS];
	logic [7:0] cram_reg [`VSDP_CRAM_DEPTH];
	logic [6:0] cram_ptr_reg;
	logic overflow_reg;
	logic [7:0] rdata_next;
	logic wr_ctrl;
	logic wr_stat;
	logic cram_hit;
	logic fifo_pop;
	logic in_lmode;
	logic in_result;
	logic [7:0] lmode_off;
	logic [7:0] result_off;

	// ----------------------------------------
	// capture and emit state
	// ----------------------------------------
	logic [7:0] buf_reg [`VSDP_BUF_DEPTH];
	logic [5:0] cnt_reg;
	vsdp_slice_t info_reg;
	logic [3:0] svc_reg;
	logic pend_reg;
	logic capt_reg;
	vsdp_state_t state_reg;
	logic [5:0] idx_reg;
	logic [5:0] cs_reg;
	logic [5:0] lm_idx;
	logic [3:0] svc_start;
	logic is_ttx;
	logic to_fifo;
	logic to_regs;
	logic [6:0] len_raw;
	logic [6:0] len_pad;
	logic [5:0] pkt_last;
	logic [5:0] dword_cnt;
	logic [5:0] data_end;
	logic in_data;
	logic [5:0] data_pos;
	logic [7:0] pkt_byte;
	logic emit;
	logic go;
	logic bt656;
	logic raw_on;
	logic fifo_full;
	logic fifo_empty;
	logic [7:0] fifo_data;
	logic [`VSDP_FIFO_AW:0] fifo_level;

	assign lmode_off = REG_ADDR - `VSDP_ADDR_LMODE_LO;
	assign result_off = REG_ADDR - `VSDP_ADDR_RESULT_LO;
	assign in_lmode = (REG_ADDR >= `VSDP_ADDR_LMODE_LO)
		&& (REG_ADDR <= `VSDP_ADDR_LMODE_HI);
	assign in_result = (REG_ADDR >= `VSDP_ADDR_RESULT_LO)
		&& (REG_ADDR <= `VSDP_ADDR_RESULT_HI);
	assign wr_ctrl = REG_WR && (REG_ADDR == `VSDP_ADDR_CTRL);
	assign wr_stat = REG_WR && (REG_ADDR == `VSDP_ADDR_STATUS);
	assign cram_hit = (REG_ADDR == `VSDP_ADDR_CRAM) && (REG_WR || REG_RD);
	assign fifo_pop = REG_RD && (REG_ADDR == `VSDP_ADDR_FIFO);
	assign bt656 = ctrl_reg[`VSDP_CTRL_BT656];
	assign raw_on = ctrl_reg[`VSDP_CTRL_RAW];

	// ----------------------------------------
	// per line service select
	// ----------------------------------------
	always_comb begin
		if (SLICE_INFO.line >= `VSDP_LINE_FIRST
			&& SLICE_INFO.line <= `VSDP_LINE_LAST) begin
			lm_idx = 6'(SLICE_INFO.line - `VSDP_LINE_FIRST)
				+ (SLICE_INFO.field2 ? `VSDP_LINES_PER_FIELD : 6'd0);
		end else begin
			lm_idx = `VSDP_LMODE_OTHER;
		end
	end
	assign svc_start = lmode_reg[lm_idx][3:0];

	generate
		for (genvar i = 0; i < `VSDP_NUM_LMODE; i++) begin : g_lmode
			always_ff @(posedge CLK or negedge RESETN) begin
				if (!RESETN) begin
					lmode_reg[i] <= `VSDP_LMODE_RESET;
				end else if (REG_WR && in_lmode && lmode_off == 8'(i)) begin
					lmode_reg[i] <= REG_WDATA;
				end
			end
		end
	endgenerate

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			ctrl_reg <= `VSDP_CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl_reg <= REG_WDATA;
		end
	end

	// ----------------------------------------
	// config ram port
	// ----------------------------------------
	// no arbitration with the engine: the host must park all lines first
	always_ff @(posedge CLK) begin
		if (REG_WR && REG_ADDR == `VSDP_ADDR_CRAM) begin
			cram_reg[cram_ptr_reg] <= REG_WDATA;
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			cram_ptr_reg <= '0;
		end else if (cram_hit) begin
			cram_ptr_reg <= cram_ptr_reg + 1'b1;
		end
	end

	// ----------------------------------------
	// slice capture
	// ----------------------------------------
	// one line buffer: slicing must not start while a packet is draining
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			cnt_reg <= '0;
			info_reg <= '0;
			svc_reg <= '0;
			capt_reg <= 1'b0;
		end else if (SLICE_START) begin
			cnt_reg <= '0;
			info_reg <= SLICE_INFO;
			svc_reg <= svc_start;
			capt_reg <= (svc_start < `VSDP_SVC_RESERVED);
		end else if (SLICE_END) begin
			capt_reg <= 1'b0;
		end else if (capt_reg && SLICE_BYTE_VALID
			&& cnt_reg < 6'(`VSDP_BUF_DEPTH)) begin
			cnt_reg <= cnt_reg + 1'b1;
		end
	end

	always_ff @(posedge CLK) begin
		if (capt_reg && SLICE_BYTE_VALID && !SLICE_START
			&& cnt_reg < 6'(`VSDP_BUF_DEPTH)) begin
			buf_reg[cnt_reg] <= SLICE_BYTE;
		end
	end

	// ----------------------------------------
	// packet layout
	// ----------------------------------------
	assign is_ttx = (svc_reg <= `VSDP_SVC_LAST_TTX);
	assign to_fifo = is_ttx || ctrl_reg[`VSDP_CTRL_TO_FIFO];
	assign to_regs = !is_ttx && ctrl_reg[`VSDP_CTRL_TO_REGS];
	assign len_raw = {1'b0, cnt_reg} + {1'b0, `VSDP_HDR_LEN}
		+ `VSDP_CS_BYTES;
	assign len_pad = (len_raw + `VSDP_DWORD_BYTES - 1'b1)
		& ~(`VSDP_DWORD_BYTES - 1'b1);
	assign pkt_last = 6'(len_pad - 1'b1);
	assign dword_cnt = 6'((len_pad - {1'b0, `VSDP_HDR_LEN}) >> 2);
	assign data_end = `VSDP_HDR_LEN + cnt_reg;
	assign in_data = idx_reg >= `VSDP_HDR_LEN && idx_reg < data_end;
	assign data_pos = idx_reg - `VSDP_HDR_LEN;

	always_comb begin
		pkt_byte = `VSDP_FILL;
		case (idx_reg)
			`VSDP_IDX_PRE0: pkt_byte = `VSDP_PRE0;
			`VSDP_IDX_TAG: begin
				if (!info_reg.field2) begin
					pkt_byte = (info_reg.line < `VSDP_TAG_SPLIT_LINE)
						? `VSDP_TAG_F1_VBI : `VSDP_TAG_F1_LATE;
				end else begin
					pkt_byte = (info_reg.line < `VSDP_TAG_SPLIT_LINE)
						? `VSDP_TAG_F2_VBI : `VSDP_TAG_F2_LATE;
				end
				pkt_byte = add_id_parity(pkt_byte[5:0]);
			end
			`VSDP_IDX_SUBTAG: pkt_byte = add_id_parity({2'b00, svc_reg});
			`VSDP_IDX_COUNT: pkt_byte = add_id_parity(dword_cnt);
			`VSDP_IDX_LINE_LO: pkt_byte = info_reg.line[7:0];
			`VSDP_IDX_LINE_HI: begin
				pkt_byte = {3'b000, info_reg.check_error, info_reg.match1,
					info_reg.match2, info_reg.line[9:8]};
			end
			default: begin
				if (idx_reg < `VSDP_HDR_LEN) begin
					pkt_byte = `VSDP_PRE1;
				end else if (in_data) begin
					pkt_byte = buf_reg[data_pos];
				end else if (idx_reg == data_end) begin
					pkt_byte = {2'b00, cs_reg};
				end
			end
		endcase
	end

	// ----------------------------------------
	// emitter
	// ----------------------------------------
	// without embedded syncs the packet only feeds the fifo or result registers, so no wait
	assign go = pend_reg && (HBLANK || !bt656);
	assign emit = (state_reg == VSDP_SEND);

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			state_reg <= VSDP_IDLE;
			idx_reg <= '0;
			cs_reg <= '0;
		end else begin
			case (state_reg)
				VSDP_IDLE: begin
					if (go) begin
						state_reg <= VSDP_SEND;
						idx_reg <= '0;
						cs_reg <= '0;
					end
				end
				VSDP_SEND: begin
					if (idx_reg >= `VSDP_IDX_TAG && idx_reg < data_end) begin
						cs_reg <= cs_reg + pkt_byte[5:0];
					end
					if (idx_reg == pkt_last) begin
						state_reg <= VSDP_IDLE;
					end else begin
						idx_reg <= idx_reg + 1'b1;
					end
				end
				default: state_reg <= VSDP_IDLE;
			endcase
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			pend_reg <= 1'b0;
		end else if (capt_reg && SLICE_END) begin
			pend_reg <= 1'b1;
		end else if (emit && idx_reg == pkt_last) begin
			pend_reg <= 1'b0;
		end
	end

	generate
		for (genvar i = 0; i < `VSDP_RESULT_REGS; i++) begin : g_result
			always_ff @(posedge CLK or negedge RESETN) begin
				if (!RESETN) begin
					result_reg[i] <= '0;
				end else if (emit && to_regs && in_data
					&& data_pos == 6'(i)) begin
					result_reg[i] <= pkt_byte;
				end
			end
		end
	endgenerate

	vsdp_fifo u_fifo (
		.clk(CLK),
		.resetn(RESETN),
		.push(emit && to_fifo),
		.push_data(pkt_byte),
		.pop(fifo_pop),
		.pop_data(fifo_data),
		.full(fifo_full),
		.empty(fifo_empty),
		.level(fifo_level)
	);

	// overflow set wins over the host clear
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			overflow_reg <= 1'b0;
		end else if (emit && to_fifo && fifo_full) begin
			overflow_reg <= 1'b1;
		end else if (wr_stat && REG_WDATA[`VSDP_STAT_OVERFLOW]) begin
			overflow_reg <= 1'b0;
		end
	end

	// ----------------------------------------
	// video output
	// ----------------------------------------
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			VID_OUT <= '0;
			ANC_ACTIVE <= 1'b0;
		end else if (bt656 && raw_on && (ACTIVE || VBLANK)) begin
			VID_OUT <= RAW_SAMPLE;
			ANC_ACTIVE <= 1'b1;
		end else if (bt656 && emit) begin
			VID_OUT <= pkt_byte;
			ANC_ACTIVE <= 1'b1;
		end else begin
			VID_OUT <= VID_IN;
			ANC_ACTIVE <= 1'b0;
		end
	end

	// ----------------------------------------
	// host read data
	// ----------------------------------------
	always_comb begin
		rdata_next = '0;
		if (in_lmode) begin
			rdata_next = lmode_reg[6'(lmode_off)];
		end else if (in_result) begin
			rdata_next = result_reg[5'(result_off)];
		end else begin
			case (REG_ADDR)
				`VSDP_ADDR_FIFO: rdata_next = fifo_empty ? '0 : fifo_data;
				`VSDP_ADDR_CTRL: rdata_next = ctrl_reg;
				`VSDP_ADDR_STATUS: begin
					rdata_next[`VSDP_STAT_NONEMPTY] = !fifo_empty;
					rdata_next[`VSDP_STAT_OVERFLOW] = overflow_reg;
					rdata_next[`VSDP_STAT_PENDING] = pend_reg;
					rdata_next[`VSDP_STAT_BUSY] = emit;
				end
				`VSDP_ADDR_FIFO_LEVEL: rdata_next = fifo_level[8:1];
				`VSDP_ADDR_CRAM: rdata_next = cram_reg[cram_ptr_reg];
				default: rdata_next = '0;
			endcase
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			REG_RDATA <= '0;
			FIFO_NONEMPTY <= 1'b0;
		end else begin
			if (REG_RD) begin
				REG_RDATA <= rdata_next;
			end
			FIFO_NONEMPTY <= !fifo_empty;
		end
	end

endmodule : vbi_sliced_data_packetizer

// file: rtl/vsdp_defs.svh
`ifndef VSDP_DEFS_SVH
`define VSDP_DEFS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define VSDP_ADDR_RESULT_LO 8'h90
`define VSDP_ADDR_RESULT_HI 8'haf
`define VSDP_ADDR_FIFO 8'hb0
`define VSDP_ADDR_CTRL 8'hc0
`define VSDP_ADDR_STATUS 8'hc1
`define VSDP_ADDR_FIFO_LEVEL 8'hc2
`define VSDP_ADDR_CRAM 8'hc3
`define VSDP_ADDR_LMODE_LO 8'hd0
`define VSDP_ADDR_LMODE_HI 8'hfc

// ----------------------------------------
// reset values and control fields
// ----------------------------------------
`define VSDP_LMODE_RESET 8'hff
`define VSDP_CTRL_RESET 8'h05
`define VSDP_CTRL_BT656 0
`define VSDP_CTRL_RAW 1
`define VSDP_CTRL_TO_FIFO 2
`define VSDP_CTRL_TO_REGS 3
`define VSDP_STAT_NONEMPTY 0
`define VSDP_STAT_OVERFLOW 1
`define VSDP_STAT_PENDING 2
`define VSDP_STAT_BUSY 3

// ----------------------------------------
// line and service codes
// ----------------------------------------
`define VSDP_NUM_LMODE 45
`define VSDP_LINES_PER_FIELD 6'd22
`define VSDP_LMODE_OTHER 6'd44
`define VSDP_LINE_FIRST 10'd6
`define VSDP_LINE_LAST 10'd27
`define VSDP_TAG_SPLIT_LINE 10'd24
`define VSDP_SVC_LAST_TTX 4'h5
`define VSDP_SVC_RESERVED 4'he

// ----------------------------------------
// packet layout
// ----------------------------------------
`define VSDP_PRE0 8'h00
`define VSDP_PRE1 8'hff
`define VSDP_FILL 8'h80
`define VSDP_TAG_F1_VBI 8'h91
`define VSDP_TAG_F1_LATE 8'h53
`define VSDP_TAG_F2_VBI 8'h55
`define VSDP_TAG_F2_LATE 8'h97
`define VSDP_IDX_PRE0 6'd0
`define VSDP_IDX_TAG 6'd3
`define VSDP_IDX_SUBTAG 6'd4
`define VSDP_IDX_COUNT 6'd5
`define VSDP_IDX_LINE_LO 6'd6
`define VSDP_IDX_LINE_HI 6'd7
`define VSDP_HDR_LEN 6'd8
`define VSDP_DWORD_BYTES 7'd4
`define VSDP_CS_BYTES 7'd1

// ----------------------------------------
// storage sizes
// ----------------------------------------
`define VSDP_BUF_DEPTH 48
`define VSDP_RESULT_REGS 32
`define VSDP_CRAM_DEPTH 128
`define VSDP_FIFO_DEPTH 512
`define VSDP_FIFO_AW 9

`endif

// file: rtl/vsdp_fifo.sv
`timescale 1ns/1ps
`include "vsdp_defs.svh"

module vsdp_fifo
	import vsdp_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic push,
	input wire logic [7:0] push_data,
	input wire logic pop,
	output logic [7:0] pop_data,
	output logic full,
	output logic empty,
	output logic [`VSDP_FIFO_AW:0] level
);
	logic [7:0] mem_reg [`VSDP_FIFO_DEPTH];
	logic [`VSDP_FIFO_AW-1:0] wr_reg;
	logic [`VSDP_FIFO_AW-1:0] rd_reg;
	logic [`VSDP_FIFO_AW:0] cnt_reg;
	logic do_push;
	logic do_pop;

	// ----------------------------------------
	// 512 byte store
	// ----------------------------------------
	// depth is a power of two, so the top count bit alone means full
	assign full = cnt_reg[`VSDP_FIFO_AW];
	assign empty = (cnt_reg == '0);
	assign level = cnt_reg;
	assign pop_data = mem_reg[rd_reg];
	assign do_push = push && !full;
	assign do_pop = pop && !empty;

	always_ff @(posedge clk) begin
		if (do_push) begin
			mem_reg[wr_reg] <= push_data;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
		end else begin
			if (do_push) begin
				wr_reg <= wr_reg + 1'b1;
			end
			if (do_pop) begin
				rd_reg <= rd_reg + 1'b1;
			end
			case ({do_push, do_pop})
				2'b10: cnt_reg <= cnt_reg + 1'b1;
				2'b01: cnt_reg <= cnt_reg - 1'b1;
				default: cnt_reg <= cnt_reg;
			endcase
		end
	end

endmodule : vsdp_fifo

// file: rtl/vsdp_pkg.sv
package vsdp_pkg;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [0:0] {
		VSDP_IDLE = 1'b0,
		VSDP_SEND = 1'b1
	} vsdp_state_t;

	typedef struct packed {
		logic [9:0] line;
		logic field2;
		logic match1;
		logic match2;
		logic check_error;
	} vsdp_slice_t;

endpackage : vsdp_pkg

// file: verification/vbi_sliced_data_packetizer_tb.sv
`timescale 1ns/1ps
`include "vsdp_defs.svh"

`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin \
	mismatches++; $display("[ERR] %s exp %h got %h", nm, ex, gt); end end

module vbi_sliced_data_packetizer_tb
	import vsdp_pkg::*;
;
	logic CLK, RESETN, REG_WR, REG_RD, SLICE_START, SLICE_BYTE_VALID;
	logic SLICE_END, HBLANK, ACTIVE, VBLANK, ANC_ACTIVE, FIFO_NONEMPTY;
	logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA, SLICE_BYTE, VID_IN;
	logic [7:0] RAW_SAMPLE, VID_OUT;
	vsdp_slice_t SLICE_INFO;
	int checks, mismatches, cs_idx;
	logic [31:0] seed = 32'h2f6d;
	logic [7:0] dat [0:63];
	logic [7:0] exp_q [$];
	logic [7:0] got_q [$];

	vbi_sliced_data_packetizer i_vbi_sliced_data_packetizer (.CLK(CLK),
		.RESETN(RESETN), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
		.REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
		.SLICE_START(SLICE_START), .SLICE_INFO(SLICE_INFO),
		.SLICE_BYTE_VALID(SLICE_BYTE_VALID), .SLICE_BYTE(SLICE_BYTE),
		.SLICE_END(SLICE_END), .HBLANK(HBLANK), .ACTIVE(ACTIVE),
		.VBLANK(VBLANK), .VID_IN(VID_IN), .RAW_SAMPLE(RAW_SAMPLE),
		.VID_OUT(VID_OUT), .ANC_ACTIVE(ANC_ACTIVE),
		.FIFO_NONEMPTY(FIFO_NONEMPTY));
	vsdp_rx_model i_vsdp_rx_model (.clk(CLK), .vid(VID_OUT),
		.anc(ANC_ACTIVE));

	// ----
	// helpers
	// ----
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic logic [7:0] par(input logic [5:0] v);
		return {~^v, ^v, v};
	endfunction : par
	task automatic build(input vsdp_slice_t s, input logic [3:0] svc,
		input int n);
		int len;
		logic [5:0] cs;
		len = ((8 + n + 1 + 3) / 4) * 4;
		exp_q = {8'h00, 8'hff, 8'hff};
		exp_q.push_back(s.line >= 10'd24 ? (s.field2 ? 8'h97 : 8'h53) :
			(s.field2 ? 8'h55 : 8'h91));
		exp_q.push_back(par({2'b00, svc}));
		exp_q.push_back(par(6'((len - 8) / 4)));
		exp_q.push_back(s.line[7:0]);
		exp_q.push_back({3'b000, s.check_error, s.match1, s.match2,
			s.line[9:8]});
		for (int i = 0; i < n; i++) exp_q.push_back(dat[i]);
		cs = 6'h00;
		for (int i = 3; i < exp_q.size(); i++) cs += exp_q[i][5:0];
		cs_idx = exp_q.size();
		exp_q.push_back({2'b00, cs});
		while (exp_q.size() < len) exp_q.push_back(8'h80);
	endtask : build
	task automatic cmp_pkt(input logic [7:0] got [$]);
		`CHK("pkt len", exp_q.size(), got.size())
		for (int i = 0; i < exp_q.size() && i < got.size(); i++) begin
			if (i == cs_idx) `CHK("checksum", exp_q[i][5:0], got[i][5:0])
			else `CHK("pkt byte", exp_q[i], got[i])
		end
	endtask : cmp_pkt
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge CLK);
		REG_ADDR <= a;
		REG_WDATA <= d;
		REG_WR <= 1'b1;
		@(posedge CLK);
		REG_WR <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge CLK);
		REG_ADDR <= a;
		REG_RD <= 1'b1;
		@(posedge CLK);
		REG_RD <= 1'b0;
		#1;
		d = REG_RDATA;
	endtask : rd
	task automatic slice(input vsdp_slice_t s, input int n);
		@(posedge CLK);
		SLICE_START <= 1'b1;
		SLICE_INFO <= s;
		for (int i = 0; i < n; i++) begin
			@(posedge CLK);
			SLICE_START <= 1'b0;
			SLICE_BYTE_VALID <= 1'b1;
			SLICE_BYTE <= dat[i];
		end
		@(posedge CLK);
		SLICE_START <= 1'b0;
		SLICE_BYTE_VALID <= 1'b0;
		SLICE_END <= 1'b1;
		@(posedge CLK);
		SLICE_END <= 1'b0;
	endtask : slice
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : complete_run

	// ----
	// clock, watchdog
	// ----
	initial begin
		CLK = 1'b0;
		forever #12.5 CLK = ~CLK;
	end
	always @(posedge CLK) VID_IN <= VID_IN + 8'h1d;
	initial begin
		repeat (100000) @(posedge CLK);
		mismatches++;
		complete_run();
	end

	// ----
	// main sequence
	// ----
	initial begin
		vsdp_slice_t s;
		logic [7:0] v, pv;
		logic [7:0] ram [0:127];
		int n;
		{RESETN, REG_WR, REG_RD, SLICE_START, SLICE_BYTE_VALID} = '0;
		{SLICE_END, HBLANK, ACTIVE, VBLANK} = '0;
		{REG_ADDR, REG_WDATA, SLICE_BYTE, VID_IN, RAW_SAMPLE} = '0;
		SLICE_INFO = '0;
		repeat (10) @(posedge CLK);
		RESETN <= 1'b1;
		rd(`VSDP_ADDR_CTRL, v); `CHK("ctrl reset", 8'h05, v)
		rd(8'hd0, v); `CHK("select reset", 8'hff, v)
		rd(8'hfc, v); `CHK("select reset", 8'hff, v)
		wr(8'h90, 8'h5a);
		rd(8'h90, v); `CHK("result ro", 8'h00, v)
		rd(8'h00, v); `CHK("unmapped", 8'h00, v)
		$display("test registers done");
		// selects still ff from reset, so the ram port is free
		for (int i = 0; i < 128; i++) begin
			ram[i] = 8'(rnd());
			wr(`VSDP_ADDR_CRAM, ram[i]);
		end
		for (int i = 0; i < 128; i++) begin
			rd(`VSDP_ADDR_CRAM, v); `CHK("cram", ram[i], v)
		end
		$display("test config ram done");
		for (int c = 0; c < 16; c++) begin
			s = vsdp_slice_t'({10'd6 + 10'(rnd() % 22), 4'(rnd())});
			n = (c == 0) ? 48 : 1 + int'(rnd() % 12);
			for (int i = 0; i < n; i++) dat[i] = 8'(rnd());
			wr(8'hd0 + 8'(s.field2 * 22) + 8'(s.line - 6), 8'(c));
			build(s, 4'(c), n);
			i_vsdp_rx_model.bytes.delete();
			slice(s, n);
			@(posedge CLK);
			HBLANK <= 1'b1;
			repeat (70) @(posedge CLK);
			HBLANK <= 1'b0;
			repeat (2) @(posedge CLK);
			if (c >= 14) `CHK("no packet", 0, i_vsdp_rx_model.bytes.size())
			else cmp_pkt(i_vsdp_rx_model.bytes);
		end
		$display("test stream packets done");
		wr(`VSDP_ADDR_CTRL, 8'h08);
		for (int k = 0; k < 600 && FIFO_NONEMPTY; k++) rd(`VSDP_ADDR_FIFO, v);
		repeat (3) @(posedge CLK);
		`CHK("fifo drained", 1'b0, FIFO_NONEMPTY)
		s = vsdp_slice_t'({10'd10, 4'(rnd())});
		s.field2 = 1'b0;
		n = 8;
		for (int i = 0; i < n; i++) dat[i] = 8'(rnd());
		wr(8'hd4, 8'h03);
		build(s, 4'h3, n);
		slice(s, n);
		repeat (70) @(posedge CLK);
		#1;
		`CHK("pass through", 8'(VID_IN - 8'h1d), VID_OUT)
		got_q.delete();
		for (int i = 0; i < exp_q.size(); i++) begin
			rd(`VSDP_ADDR_FIFO, v);
			got_q.push_back(v);
		end
		cmp_pkt(got_q);
		rd(8'h90, v); `CHK("ttx not in regs", 8'h00, v)
		wr(8'hd4, 8'h07);
		slice(s, n);
		repeat (70) @(posedge CLK);
		for (int i = 0; i < n; i++) begin
			rd(8'h90 + 8'(i), v); `CHK("result reg", dat[i], v)
		end
		`CHK("cc not in fifo", 1'b0, FIFO_NONEMPTY)
		$display("test fifo and result regs done");
		wr(`VSDP_ADDR_CTRL, 8'h03);
		v = 8'h00;
		for (int i = 0; i < 17; i++) begin
			@(posedge CLK);
			pv = v;
			v = 8'(rnd());
			RAW_SAMPLE <= v;
			ACTIVE <= (i < 8);
			VBLANK <= (i >= 8) && (i < 16);
			#1;
			if (i > 0) `CHK("raw sample", pv, VID_OUT)
			if (i > 0) `CHK("raw flag", 1'b1, ANC_ACTIVE)
		end
		repeat (2) @(posedge CLK);
		wr(`VSDP_ADDR_CTRL, 8'h05);
		$display("test raw output done");
		complete_run();
	end
endmodule : vbi_sliced_data_packetizer_tb

// file: verification/vsdp_chk.sv
`timescale 1ns/1ps
`include "vsdp_defs.svh"

module vsdp_chk
	import vsdp_pkg::*;
(
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [7:0] REG_RDATA,
	input wire logic HBLANK,
	input wire logic ACTIVE,
	input wire logic VBLANK,
	input wire logic [7:0] RAW_SAMPLE,
	input wire logic [7:0] VID_OUT,
	input wire logic ANC_ACTIVE
);
	// ----
	// shadow of ctrl, packet length count
	// ----
	logic [7:0] ctrl_reg;
	logic [6:0] cnt_reg;
	logic raw_on;
	logic pkt_on;
	assign raw_on = ctrl_reg[`VSDP_CTRL_RAW];
	// raw output also raises the flag, so keep it apart
	assign pkt_on = ANC_ACTIVE && !raw_on;
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			ctrl_reg <= `VSDP_CTRL_RESET;
		end else if (REG_WR && REG_ADDR == `VSDP_ADDR_CTRL) begin
			ctrl_reg <= REG_WDATA;
		end
	end
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			cnt_reg <= 7'h00;
		end else begin
			cnt_reg <= pkt_on ? cnt_reg + 7'h01 : 7'h00;
		end
	end
	// ----
	// assertions
	// ----
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESETN);
	unmapped_read_a: assert property (
		REG_RD && REG_ADDR == 8'h00 |=> REG_RDATA == 8'h00)
		else $error("unmapped read not zero");
	rdata_hold_a: assert property (
		!REG_RD |=> $stable(REG_RDATA))
		else $error("read data moved without read");
	raw_follow_a: assert property (
		raw_on && ctrl_reg[`VSDP_CTRL_BT656] && (ACTIVE || VBLANK)
		|=> ANC_ACTIVE && VID_OUT == $past(RAW_SAMPLE))
		else $error("raw sample not passed");
	preamble_a: assert property (
		$rose(pkt_on) && !$past(raw_on) |-> VID_OUT == 8'h00
		##1 VID_OUT == 8'hff ##1 VID_OUT == 8'hff)
		else $error("bad preamble");
	id_parity_a: assert property (
		$rose(pkt_on) && !$past(raw_on) |-> ##3 (VID_OUT[6] == ^VID_OUT[5:0]
		&& VID_OUT[7] == !VID_OUT[6]) [*3])
		else $error("bad id parity");
	did_fixed_a: assert property (
		$rose(pkt_on) && !$past(raw_on) |-> ##3 VID_OUT[5:3] == 3'b010)
		else $error("bad data id fixed bits");
	pkt_len_a: assert property (
		$fell(pkt_on) |-> cnt_reg[1:0] == 2'h0 && cnt_reg <= 7'd60)
		else $error("bad packet length");
	hblank_start_a: assert property (
		$rose(pkt_on) && !$past(raw_on) |-> $past(HBLANK, 2))
		else $error("packet outside blanking");
	no_discrete_a: assert property (
		!ctrl_reg[`VSDP_CTRL_BT656] && !$past(ctrl_reg[`VSDP_CTRL_BT656])
		|-> !ANC_ACTIVE)
		else $error("insertion with discrete syncs");
endmodule : vsdp_chk

bind vbi_sliced_data_packetizer vsdp_chk i_vsdp_chk (.CLK(CLK),
	.RESETN(RESETN), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
	.REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
	.HBLANK(HBLANK), .ACTIVE(ACTIVE), .VBLANK(VBLANK),
	.RAW_SAMPLE(RAW_SAMPLE), .VID_OUT(VID_OUT), .ANC_ACTIVE(ANC_ACTIVE));

// file: verification/vsdp_rx_model.sv
`timescale 1ns/1ps

module vsdp_rx_model (
	input wire logic clk,
	input wire logic [7:0] vid,
	input wire logic anc
);
	// ----
	// stream receiver: keeps flagged bytes
	// ----
	logic [7:0] bytes [$];
	always @(posedge clk) begin
		if (anc) begin
			bytes.push_back(vid);
		end
	end
endmodule : vsdp_rx_model
